/* File: shared/tawi_defs.svh */
// Constants of the trap and wake-up interrupt block
// What this block does
// - Trap pending flag is internal only; no bus register ever shows or changes it.
// - Reset clears the trap pending flag.
// - A trap sets the trap pending flag to one.
// - Only the clear-trap instruction or reset clears the trap pending flag.
// - Fetching opcode 00 into the instruction register raises a trap.
// - Fetch from absent program memory returns zero, decoded as the trap opcode.
// - Popping the stack past 06F loads 7FFF into the program counter.
// - Trap leaves global enable alone; pending flag blocks others, steers vector select.
// - While the trap pending flag is set, only another trap is accepted.
// - Trap is taken at once and outranks every other source.
// - Trap return address is the trap opcode's own address; return-and-skip resumes.
// - Once the pending flag is cleared, maskable requests are accepted again.
// - Eight edge-sensitive wake-up inputs share one service vector.
// - Wake enable register enables each wake interrupt separately.
// - Wake edge select picks rising or falling trigger per input.
// - Detected edges latch into the wake pending register.
// - Port master enable gates all wake interrupts as a group.
// - Global enable gates all maskable delivery, wake-up included.
// - Wake from halt with port interrupt off resumes at the next instruction.
// - Wake from halt with port interrupt and global enable both on runs the service routine first.
// - Maskable never preempts a running maskable routine; a trap preempts a maskable one.
// - Vector select gives the trap top rank at offset FE and FF.
`ifndef TAWI_DEFS_SVH
`define TAWI_DEFS_SVH
`define TAWI_OP_TRAP      8'h00
`define TAWI_SP_LIMIT     8'h6f
`define TAWI_PC_OVERPOP   15'h7fff
`define TAWI_VEC_TRAP     8'hfe
`define TAWI_VEC_WAKE     8'he2
`define TAWI_VEC_DEFAULT  8'he0
`define TAWI_ADR_WAKE_EN  8'h00
`define TAWI_ADR_WAKE_EDG 8'h04
`define TAWI_ADR_WAKE_PND 8'h08
`define TAWI_ADR_CTRL     8'h0c
`define TAWI_ADR_STATUS   8'h10
`define TAWI_CTRL_GIE     0
`define TAWI_CTRL_MEN     1
`define TAWI_RST_WAKE     8'h00
`define TAWI_RST_GIE      1'b0
`define TAWI_RST_MEN      1'b0
`endif

/* File: shared/tawi_pkg.sv */
// Types shared by the trap and wake-up interrupt block
package tawi_pkg;
	// Instruction fetch as seen by the block
	typedef struct packed {
		logic        valid;
		logic [14:0] addr;
		logic [7:0]  data;
		logic        present;
	} tawi_fetch_t;
	// Core events reported to the block
	typedef struct packed {
		logic       clear_trap_pending_instr;
		logic       take;
		logic       return_from_irq_instr;
		logic       return_and_skip_instr;
		logic       vector_select_instr;
		logic       pop;
		logic [7:0] pop_sp;
		logic       halted;
	} tawi_cmd_t;
	// Service context
	typedef enum logic [2:0] {
		TAWI_IDLE = 3'b001,
		TAWI_MSK  = 3'b010,
		TAWI_TRAP = 3'b100
	} tawi_state_t;
endpackage

/* File: verilog/tawi_ctrl.sv */
// Trap and wake-up port interrupt controller with a classic Wishbone slave
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`include "tawi_defs.svh"
module tawi_ctrl (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	input  wire logic                 wb_we_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_cyc_i,
	output logic                      wb_ack_o,
	input  wire tawi_pkg::tawi_fetch_t fetch_i,
	input  wire tawi_pkg::tawi_cmd_t  cmd_i,
	input  wire logic [7:0]           wake_pins_i,
	output logic [7:0]                ir_o,
	output logic                      trap_take_o,
	output logic [14:0]               trap_ret_addr_o,
	output logic                      pc_load_o,
	output logic [14:0]               pc_load_addr_o,
	output logic                      irq_o,
	output logic [7:0]                vis_offset_o,
	output logic                      wake_exit_o,
	output logic                      wake_isr_o
);

	// Register state
	logic [7:0]            wake_en;
	logic [7:0]            wake_edge;
	logic [7:0]            wake_pend;
	logic [7:0]            pins_prev;
	logic                  global_irq_enable;
	logic                  men;
	logic                  trap_pend;
	tawi_pkg::tawi_state_t state;
	tawi_pkg::tawi_state_t next_state;

	// Bus decode
	wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
	wire hit_en    = (wb_adr_i == `TAWI_ADR_WAKE_EN);
	wire hit_edg   = (wb_adr_i == `TAWI_ADR_WAKE_EDG);
	wire hit_pnd   = (wb_adr_i == `TAWI_ADR_WAKE_PND);
	wire hit_ctrl  = (wb_adr_i == `TAWI_ADR_CTRL);
	wire hit_stat  = (wb_adr_i == `TAWI_ADR_STATUS);
	wire wr_en     = bus_wr & hit_en;
	wire wr_edg    = bus_wr & hit_edg;
	wire wr_pnd    = bus_wr & hit_pnd;
	wire wr_ctrl   = bus_wr & hit_ctrl;

	// Fetch path: absent memory reads as zero, so it decodes as a trap
	wire [7:0] fetched   = fetch_i.present ? fetch_i.data : 8'h00;
	wire       trap_fire = fetch_i.valid & (fetched == `TAWI_OP_TRAP);
	wire       over_pop  = cmd_i.pop & (cmd_i.pop_sp > `TAWI_SP_LIMIT);

	// Wake edge detection per pin; edge select 1 means falling
	wire [7:0] rise_hit = wake_pins_i & ~pins_prev;
	wire [7:0] fall_hit = ~wake_pins_i & pins_prev;
	wire [7:0] edge_hit = (wake_edge & fall_hit) | (~wake_edge & rise_hit);
	// Changing edge select while a pin is steady cannot trigger: detection needs a transition
	wire [7:0] next_pend = edge_hit | (wake_pend & ~(wr_pnd ? wb_dat_i[7:0] : 8'h00));
	wire       wake_any  = |(wake_pend & wake_en);
	wire       wake_req  = global_irq_enable & men & wake_any;

	// Maskable delivery: blocked by pending trap or a running maskable routine
	assign irq_o = wake_req & ~trap_pend & (state != tawi_pkg::TAWI_MSK);

	// Trap pending flag: set wins over the clear instruction
	wire next_trap_pend = trap_fire | (trap_pend & ~cmd_i.clear_trap_pending_instr);

	// Global enable: core clears it on take, return from interrupt sets it, else software
	wire next_gie = cmd_i.take ? 1'b0 :
	                cmd_i.return_from_irq_instr ? 1'b1 :
	                wr_ctrl    ? wb_dat_i[`TAWI_CTRL_GIE] : global_irq_enable;

	// Vector selection rank: trap, wake, default
	wire [7:0] next_vis = trap_pend ? `TAWI_VEC_TRAP :
	                      (men & wake_any) ? `TAWI_VEC_WAKE :
	                      `TAWI_VEC_DEFAULT;

	// Read mux; unmapped addresses read zero and still acknowledge
	wire [31:0] rd_data = hit_en   ? {24'h000000, wake_en} :
	                      hit_edg  ? {24'h000000, wake_edge} :
	                      hit_pnd  ? {24'h000000, wake_pend} :
	                      hit_ctrl ? {30'h00000000, men, global_irq_enable} :
	                      hit_stat ? {28'h0000000, state == tawi_pkg::TAWI_TRAP,
	                                  state == tawi_pkg::TAWI_MSK, wake_req, irq_o} :
	                      32'h00000000;

	// Service context tracking
	always_comb begin
		next_state = state;
		case (state)
			tawi_pkg::TAWI_IDLE: begin
				if (trap_fire)
					next_state = tawi_pkg::TAWI_TRAP;
				else if (cmd_i.take)
					next_state = tawi_pkg::TAWI_MSK;
			end
			tawi_pkg::TAWI_MSK: begin
				if (trap_fire)
					next_state = tawi_pkg::TAWI_TRAP;
				else if (cmd_i.return_from_irq_instr | cmd_i.return_and_skip_instr)
					next_state = tawi_pkg::TAWI_IDLE;
			end
			tawi_pkg::TAWI_TRAP: begin
				// A cleared flag lets a maskable routine nest inside the trap routine
				if (cmd_i.take)
					next_state = tawi_pkg::TAWI_MSK;
				else if (cmd_i.return_from_irq_instr | cmd_i.return_and_skip_instr)
					next_state = tawi_pkg::TAWI_IDLE;
			end
			default: next_state = tawi_pkg::TAWI_IDLE;
		endcase
	end

	// Bus answer: one wait state, ack drops the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_data : 32'h00000000;
		end
	end

	// Software registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_en   <= `TAWI_RST_WAKE;
			wake_edge <= `TAWI_RST_WAKE;
			men       <= `TAWI_RST_MEN;
			global_irq_enable       <= `TAWI_RST_GIE;
		end else begin
			if (wr_en)
				wake_en <= wb_dat_i[7:0];
			if (wr_edg)
				wake_edge <= wb_dat_i[7:0];
			if (wr_ctrl)
				men <= wb_dat_i[`TAWI_CTRL_MEN];
			global_irq_enable <= next_gie;
		end
	end

	// Wake pending and pin history; software clears by writing ones
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_pend <= `TAWI_RST_WAKE;
			pins_prev <= 8'h00;
		end else begin
			wake_pend <= next_pend;
			pins_prev <= wake_pins_i;
		end
	end

	// Trap flag and context; the flag has no bus path at all
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trap_pend <= 1'b0;
			state     <= tawi_pkg::TAWI_IDLE;
		end else begin
			trap_pend <= next_trap_pend;
			state     <= next_state;
		end
	end

	// Core-facing registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir_o            <= 8'h00;
			trap_take_o     <= 1'b0;
			trap_ret_addr_o <= 15'h0000;
			pc_load_o       <= 1'b0;
			pc_load_addr_o  <= 15'h0000;
			vis_offset_o    <= `TAWI_VEC_DEFAULT;
		end else begin
			if (fetch_i.valid)
				ir_o <= fetched;
			trap_take_o <= trap_fire;
			if (trap_fire)
				trap_ret_addr_o <= fetch_i.addr;
			pc_load_o <= over_pop;
			if (over_pop)
				pc_load_addr_o <= `TAWI_PC_OVERPOP;
			if (cmd_i.vector_select_instr)
				vis_offset_o <= next_vis;
		end
	end

	// Halt exit: any enabled pending pin wakes; isr flag says whether to service first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wake_exit_o <= 1'b0;
			wake_isr_o  <= 1'b0;
		end else begin
			wake_exit_o <= cmd_i.halted & wake_any;
			wake_isr_o  <= cmd_i.halted & wake_any & men & global_irq_enable;
		end
	end

	// Checks
	default clocking tawi_cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence trap_entry_s;
		trap_fire ##1 (trap_take_o && trap_pend);
	endsequence

	property trap_entry_p;
		trap_fire |-> trap_entry_s;
	endproperty

	trap_entry_a: assert property (trap_entry_p)
		else $error("Trap not taken the cycle after opcode 00");

	trap_set_a: assert property (trap_fire |=> trap_pend)
		else $error("Trap pending flag not set");

	trap_hold_a: assert property (trap_pend && !cmd_i.clear_trap_pending_instr |=> trap_pend)
		else $error("Trap pending flag cleared without clear instruction");

	clear_trap_pending_instr_clear_a: assert property (cmd_i.clear_trap_pending_instr && !trap_fire |=> !trap_pend)
		else $error("Clear instruction did not clear trap pending");

	ret_addr_a: assert property (trap_fire |=> trap_ret_addr_o == $past(fetch_i.addr))
		else $error("Trap return address is not the trap opcode address");

	zero_fetch_a: assert property (fetch_i.valid && !fetch_i.present |=> ir_o == 8'h00)
		else $error("Absent memory fetch did not read zero");

	over_pop_a: assert property (over_pop |=> pc_load_o && pc_load_addr_o == 15'h7fff)
		else $error("Over-pop did not load the top program address");

	trap_lock_a: assert property (trap_pend |-> !irq_o)
		else $error("Maskable request while trap pending");

	irq_gate_a: assert property (irq_o |-> global_irq_enable && men && |(wake_pend & wake_en))
		else $error("Wake request without its enables");

	no_preempt_a: assert property (state == tawi_pkg::TAWI_MSK |-> !irq_o)
		else $error("Maskable request during maskable routine");

	gie_keep_a: assert property (trap_fire && !cmd_i.take && !cmd_i.return_from_irq_instr && !wr_ctrl
		|=> global_irq_enable == $past(global_irq_enable))
		else $error("Trap changed the global enable");

	vis_rank_a: assert property (cmd_i.vector_select_instr && trap_pend |=> vis_offset_o == 8'hfe)
		else $error("Vector select did not rank the trap first");

	wake_latch_a: assert property (|edge_hit |=> |wake_pend)
		else $error("Wake edge was not latched");

	wake_isr_a: assert property (cmd_i.halted && wake_any && !(men && global_irq_enable)
		|=> wake_exit_o && !wake_isr_o)
		else $error("Wake with port interrupt off asked for service");

	// Bus answer in steps: taken, acknowledged once, then dropped
	sequence bus_take_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence bus_answer_s;
		##1 wb_ack_o ##1 !wb_ack_o;
	endsequence

	ack_pulse_a: assert property (bus_take_s |-> bus_answer_s)
		else $error("Bus acknowledge not a single cycle after the request");

	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("Acknowledge without a request");

	// Idle read data stays zero so a stale word is never mistaken for an answer
	ack_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("Read data not zero outside acknowledge");

	stat_hide_a: assert property (wb_ack_o && !$past(wb_we_i)
		&& $past(wb_adr_i) == `TAWI_ADR_STATUS |-> wb_dat_o[31:4] == 28'h0000000)
		else $error("Status read shows more than its four bits");

	// Trap flag life cycle
	trap_reset_a: assert property ($past(rst_i) |-> !trap_pend)
		else $error("Trap pending flag set after reset");

	trap_again_a: assert property (trap_fire && trap_pend |=> trap_pend)
		else $error("Nested trap lost the pending flag");

	trap_fall_a: assert property ($fell(trap_pend) |-> $past(cmd_i.clear_trap_pending_instr) || $past(rst_i))
		else $error("Trap pending flag fell without the clear instruction");

	trap_ir_a: assert property (trap_fire |=> ir_o == `TAWI_OP_TRAP)
		else $error("Trap opcode not in the instruction register");

	plain_fetch_a: assert property (fetch_i.valid && fetched != `TAWI_OP_TRAP
		|=> !trap_take_o)
		else $error("Plain opcode raised a trap");

	no_trap_a: assert property (!trap_fire |=> !trap_take_o)
		else $error("Trap taken without a trap fetch");

	trap_state_a: assert property (trap_fire |=> state == tawi_pkg::TAWI_TRAP)
		else $error("Trap fetch did not enter the trap context");

	ret_hold_a: assert property (!trap_fire |=> $stable(trap_ret_addr_o))
		else $error("Trap return address moved without a trap");

	// Over-pop recovery
	pop_ok_a: assert property (cmd_i.pop && cmd_i.pop_sp <= `TAWI_SP_LIMIT
		|=> !pc_load_o)
		else $error("Pop within the limit loaded the program counter");

	pop_hold_a: assert property (!over_pop |=> $stable(pc_load_addr_o))
		else $error("Program counter load address moved");

	// Vector selection for the non-trap cases
	vis_wake_a: assert property (cmd_i.vector_select_instr && !trap_pend && men && wake_any
		|=> vis_offset_o == `TAWI_VEC_WAKE)
		else $error("Vector select missed the wake vector");

	vis_default_a: assert property (cmd_i.vector_select_instr && !trap_pend && !(men && wake_any)
		|=> vis_offset_o == `TAWI_VEC_DEFAULT)
		else $error("Vector select missed the default vector");

	vis_hold_a: assert property (!cmd_i.vector_select_instr |=> $stable(vis_offset_o))
		else $error("Vector offset moved without vector select");

	// Context tracking
	state_onehot_a: assert property ($onehot(state))
		else $error("Service context not one-hot");

	trap_preempt_a: assert property (state == tawi_pkg::TAWI_MSK && trap_fire
		|=> state == tawi_pkg::TAWI_TRAP)
		else $error("Trap did not preempt the maskable routine");

	trap_nest_a: assert property (state == tawi_pkg::TAWI_TRAP && !trap_pend
		&& wake_req |-> irq_o)
		else $error("Maskable request held back after the flag was cleared");

	// Maskable gating, each enable alone must be able to block
	gie_gate_a: assert property (!global_irq_enable |-> !irq_o)
		else $error("Request with global enable off");

	men_gate_a: assert property (!men |-> !irq_o)
		else $error("Request with port master enable off");

	en_gate_a: assert property ((wake_pend & wake_en) == 8'h00 |-> !irq_o)
		else $error("Request with no enabled pending pin");

	gie_take_a: assert property (cmd_i.take |=> !global_irq_enable)
		else $error("Global enable kept on interrupt take");

	// Register writes land at the edge that takes them
	en_write_a: assert property (wr_en |=> wake_en == $past(wb_dat_i[7:0]))
		else $error("Wake enable write lost");

	edg_write_a: assert property (wr_edg |=> wake_edge == $past(wb_dat_i[7:0]))
		else $error("Wake edge select write lost");

	men_write_a: assert property (wr_ctrl |=> men == $past(wb_dat_i[`TAWI_CTRL_MEN]))
		else $error("Port master enable write lost");

	// Wake pending holds, clears on request, and exit follows the halt level
	pend_hold_a: assert property (edge_hit == 8'h00 && !wr_pnd |=> $stable(wake_pend))
		else $error("Wake pending changed without an edge or a clear");

	pend_clear_a: assert property (wr_pnd && edge_hit == 8'h00
		|=> (wake_pend & $past(wb_dat_i[7:0])) == 8'h00)
		else $error("Wake pending clear did not clear");

	halt_exit_a: assert property (!cmd_i.halted |=> !wake_exit_o && !wake_isr_o)
		else $error("Halt exit raised while running");

	wake_isr_on_a: assert property (cmd_i.halted && wake_any && men && global_irq_enable
		|=> wake_exit_o && wake_isr_o)
		else $error("Wake with port interrupt on skipped service");

endmodule

/* File: dv/tawi_core_model.sv */
// Behavioural core model that loads instructions and reports core events
`timescale 1ns/10ps
module tawi_core_model (
	input  wire logic              clk_i,
	output tawi_pkg::tawi_fetch_t  fetch_o,
	output tawi_pkg::tawi_cmd_t    cmd_o
);
	// Everything idles low until the first load, pulse or halt
	initial begin
		fetch_o = '0;
		cmd_o = '0;
	end
	// One instruction load; absent memory puts noise on the data lines
	task automatic fetch(input logic [14:0] a, input logic [7:0] d, input logic p);
		@(posedge clk_i);
		fetch_o <= '{1'b1, a, p ? d : 8'(($urandom % 255) + 1), p};
		@(posedge clk_i);
		fetch_o.valid <= 1'b0;
		// Stale data must not pass for a fresh load
		fetch_o.data <= ~fetch_o.data;
	endtask
	// One-cycle event pulse; the halt level survives the pulse
	task automatic pulse(input tawi_pkg::tawi_cmd_t c);
		@(posedge clk_i);
		cmd_o <= c | {14'h0, cmd_o.halted};
		@(posedge clk_i);
		cmd_o <= {14'h0, cmd_o.halted};
	endtask
	// Halt level held until the core wakes
	task automatic halt(input logic h);
		@(posedge clk_i);
		cmd_o.halted <= h;
	endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the trap and wake-up interrupt controller
`timescale 1ns/10ps
module tb;
	localparam logic [14:0] C_CLR   = 15'h4000;
	localparam logic [14:0] C_TAKE  = 15'h2000;
	localparam logic [14:0] C_RETURN_FROM_IRQ_INSTR  = 15'h1000;
	localparam logic [14:0] C_RETURN_AND_SKIP_INSTR = 15'h0800;
	localparam logic [14:0] C_VIS   = 15'h0400;
	logic                  clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic                  cyc = 1'b0;
	logic                  we = 1'b0;
	logic [7:0]            adr = 8'h00;
	logic [31:0]           dat = 32'h0;
	logic [7:0]            pins = 8'h00;
	logic [7:0]            edg;
	logic [31:0]           wb_dat_o;
	logic                  wb_ack_o, trap_take_o, pc_load_o, irq_o, wake_exit_o, wake_isr_o;
	logic [7:0]            ir_o, vis_offset_o;
	logic [14:0]           trap_ret_addr_o, pc_load_addr_o;
	tawi_pkg::tawi_fetch_t fetch;
	tawi_pkg::tawi_cmd_t   cmd;
	int                    error_cnt = 0;
	int                    n_tests = 0;
	logic [31:0]           rq[$];
	logic [14:0]           tq[$];

	// Free-running 10 MHz clock
	always #50 clk_i = ~clk_i;

	tawi_core_model core_u (.clk_i, .fetch_o(fetch), .cmd_o(cmd));
	tawi_ctrl dut_u (.clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o,
		.wb_we_i(we), .wb_sel_i(4'hf), .wb_stb_i(cyc), .wb_cyc_i(cyc), .wb_ack_o,
		.fetch_i(fetch), .cmd_i(cmd), .wake_pins_i(pins), .ir_o, .trap_take_o,
		.trap_ret_addr_o, .pc_load_o, .pc_load_addr_o, .irq_o, .vis_offset_o,
		.wake_exit_o, .wake_isr_o);

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask
	// Classic cycle; on reads d is the expected data, noted for the monitor
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		if (!w) rq.push_back(d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		if (n >= 40) chk("ack", 1, 0);
		cyc <= 1'b0;
	endtask
	task automatic trap(logic [14:0] a, logic p);
		tq.push_back(a);
		core_u.fetch(a, 8'h00, p);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Results are matched against the oldest note; an unexpected trap finds none
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && !we) chk("rdata", rq.size() ? rq.pop_front() : '1, wb_dat_o);
		if (trap_take_o === 1'b1) begin
			chk("ret", tq.size() ? 32'(tq.pop_front()) : '1, 32'(trap_ret_addr_o));
			chk("ir", 0, ir_o);
		end
	end
	// Watchdog well beyond the expected run of under 300 cycles
	initial begin
		#(100 * 5000);
		chk("watchdog", 0, 1);
		results;
	end

	initial begin
		void'($urandom(32'h0b67b233));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, including unmapped places; trap flag never shows
		for (int a = 0; a <= 32; a += 4) wb(0, 8'(a), 0);
		wb(1, 8'h20, '1);
		wb(0, 8'h20, 0);
		// Random edge polarity per pin; settle pins, then clear what that caused
		edg = 8'($urandom);
		wb(1, 8'h04, {24'h0, edg});
		pins <= edg;
		wb(1, 8'h00, 32'hff);
		wb(1, 8'h0c, 32'h3);
		wb(1, 8'h08, 32'hff);
		for (int i = 0; i < 8; i++) begin
			pins[i] <= ~edg[i];
			repeat (3) @(posedge clk_i);
			wb(0, 8'h08, 32'(1 << i));
			#1;
			chk("irq", 1, irq_o);
			wb(1, 8'h08, 32'(1 << i));
			pins[i] <= edg[i];
			repeat (3) @(posedge clk_i);
			wb(0, 8'h08, 0);
		end
		// Every mix of global and master enable, then the pin enable
		pins[0] <= ~edg[0];
		repeat (3) @(posedge clk_i);
		for (int c = 0; c < 4; c++) begin
			wb(1, 8'h0c, 32'(c));
			#1;
			chk("irq", 32'(c == 3), irq_o);
		end
		wb(1, 8'h00, 32'hfe);
		#1;
		chk("irq", 0, irq_o);
		wb(1, 8'h00, 32'hff);
		// Halt exit without and with the port interrupt
		core_u.halt(1'b1);
		wb(1, 8'h0c, 32'h1);
		repeat (2) @(posedge clk_i);
		#1;
		chk("exit", 1, wake_exit_o);
		chk("isr", 0, wake_isr_o);
		wb(1, 8'h0c, 32'h3);
		repeat (2) @(posedge clk_i);
		#1;
		chk("isr", 1, wake_isr_o);
		core_u.halt(1'b0);
		core_u.pulse(C_VIS);
		#1;
		chk("vec", 8'he2, vis_offset_o);
		// Trap with a wake request waiting: it blocks and outranks it
		trap(15'h0123, 1'b1);
		#1;
		chk("irq", 0, irq_o);
		core_u.pulse(C_VIS);
		#1;
		chk("vec", 8'hfe, vis_offset_o);
		wb(0, 8'h0c, 32'h3);
		wb(0, 8'h10, 32'ha);
		core_u.pulse(C_RETURN_AND_SKIP_INSTR);
		#1;
		chk("irq", 0, irq_o);
		trap(15'h7fff, 1'b0);
		core_u.pulse(C_CLR);
		#1;
		chk("irq", 1, irq_o);
		core_u.pulse(C_RETURN_AND_SKIP_INSTR);
		// Maskable routine: nothing maskable preempts it, a trap does
		core_u.pulse(C_TAKE);
		wb(0, 8'h0c, 32'h2);
		#1;
		chk("irq", 0, irq_o);
		trap(15'h4abc, 1'b1);
		core_u.pulse(C_CLR);
		core_u.pulse(C_RETURN_FROM_IRQ_INSTR);
		wb(0, 8'h0c, 32'h3);
		// Stack pops just past and at the limit
		core_u.pulse(15'h02e0);
		#1;
		chk("pcld", 1, pc_load_o);
		chk("pcad", 15'h7fff, pc_load_addr_o);
		core_u.pulse(15'h02de);
		#1;
		chk("pcld", 0, pc_load_o);
		// Nothing pending: vector select falls to the default entry
		wb(1, 8'h08, 32'hff);
		core_u.pulse(C_VIS);
		#1;
		chk("vec", 8'he0, vis_offset_o);
		// A plain opcode loads without a trap
		core_u.fetch(15'h0200, 8'h3c, 1'b1);
		#1;
		chk("ir", 8'h3c, ir_o);
		repeat (3) @(posedge clk_i);
		results;
	end
endmodule
